// ---- design/eiel_top.sv ----
// edge interrupt/event line controller: per-line edge detect, mask, pending
// assumes apb master on pclk; line inputs are asynchronous and resynchronised
`timescale 1ns/10ps

module eiel_top
  import eiel_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_LINES-1:0] line_in,
  output logic      [NUM_LINES-1:0] line_irq,
  output logic      [NUM_LINES-1:0] line_event,
  output logic                      wakeup_req,
  output logic                      irq
);

  eiel_req_t                 req;
  eiel_phase_t               phase_reg;
  eiel_phase_t               phase_next;

  logic [NUM_LINES-1:0]      sync1_reg;
  logic [NUM_LINES-1:0]      sync2_reg;
  logic [NUM_LINES-1:0]      prev_reg;
  logic [NUM_LINES-1:0]      mask_reg;
  logic [NUM_LINES-1:0]      evmask_reg;
  logic [NUM_LINES-1:0]      rise_reg;
  logic [NUM_LINES-1:0]      fall_reg;
  logic [NUM_LINES-1:0]      pend_reg;
  logic [NUM_LINES-1:0]      pend_next;
  logic [NUM_IO_LINES-1:0]   wakeen_reg;
  logic [STAT_W-1:0]         stat_reg;
  logic [STAT_W-1:0]         stat_next;
  logic [STAT_W-1:0]         stmask_reg;

  wire  [NUM_LINES-1:0]      edge_hit;
  wire  [NUM_LINES-1:0]      sw_hit;
  wire  [NUM_LINES-1:0]      trig;
  wire  [NUM_LINES-1:0]      clr_bits;
  wire  [STAT_W-1:0]         stat_evt;
  wire                       wake_hit;
  wire                       acc;
  wire                       wr_acc;
  wire                       rd_acc;
  wire                       addr_ok;
  wire  [31:0]               rd_mux;
  wire                       wr_mask;
  wire                       wr_evmask;
  wire                       wr_rise;
  wire                       wr_fall;
  wire                       wr_wakeen;
  wire                       wr_stmask;
  wire                       rd_stat;
  wire  [STAT_W-1:0]         stat_clr;
  wire                       access_next;

  function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    sel = (a == off);
  endfunction

  assign req.addr  = paddr;
  assign req.wr    = pwrite;
  assign req.wdata = pwdata;

  // access completes in the cycle after setup: one wait-free access phase
  assign acc    = psel && penable && (phase_reg == EIEL_ACCESS);
  assign wr_acc = acc && req.wr;
  assign rd_acc = acc && !req.wr;
  assign addr_ok = sel(req.addr, OFF_MASK)   || sel(req.addr, OFF_EVMASK) ||
                   sel(req.addr, OFF_RISE)   || sel(req.addr, OFF_FALL)   ||
                   sel(req.addr, OFF_SWTRIG) || sel(req.addr, OFF_PEND)   ||
                   sel(req.addr, OFF_LEVEL)  || sel(req.addr, OFF_WAKEEN) ||
                   sel(req.addr, OFF_STAT)   || sel(req.addr, OFF_STMASK);

  // per-register write strobes, valid only in the access cycle
  assign wr_mask     = wr_acc && sel(req.addr, OFF_MASK);
  assign wr_evmask   = wr_acc && sel(req.addr, OFF_EVMASK);
  assign wr_rise     = wr_acc && sel(req.addr, OFF_RISE);
  assign wr_fall     = wr_acc && sel(req.addr, OFF_FALL);
  assign wr_wakeen   = wr_acc && sel(req.addr, OFF_WAKEEN);
  assign wr_stmask   = wr_acc && sel(req.addr, OFF_STMASK);
  assign access_next = (phase_next == EIEL_ACCESS);

  always_comb
  begin
    phase_next = phase_reg;
    unique case (phase_reg)
      EIEL_IDLE:   if (psel && !penable) phase_next = EIEL_ACCESS;
      EIEL_ACCESS: phase_next = EIEL_IDLE;
      default:     phase_next = EIEL_IDLE;
    endcase
  end

  // per-line edge detection on synchronised inputs
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++)
    begin : g_line
      assign edge_hit[g] = (rise_reg[g] && sync2_reg[g] && !prev_reg[g]) ||
                           (fall_reg[g] && !sync2_reg[g] && prev_reg[g]);
    end
  endgenerate

  // a software trigger write acts like a detected edge on that line
  assign sw_hit   = (wr_acc && sel(req.addr, OFF_SWTRIG)) ? req.wdata[NUM_LINES-1:0] :
                    '0;
  assign trig     = edge_hit | sw_hit;
  // only ones clear; zeros leave the bit alone
  assign clr_bits = (wr_acc && sel(req.addr, OFF_PEND)) ?
                    req.wdata[NUM_LINES-1:0] : '0;
  // a new edge in the clearing cycle wins so no request is lost
  assign pend_next = (pend_reg & ~clr_bits) | trig;

  // wakeup ignores the interrupt mask: deep stop only needs an enabled io edge
  assign wake_hit = |(trig[NUM_IO_LINES-1:0] & wakeen_reg);

  assign stat_evt = {wake_hit, |trig};
  // a read clears only the bits it returned, so an event that lands between
  // setup and access survives for the next read; a new event still sets
  assign rd_stat   = rd_acc && sel(req.addr, OFF_STAT);
  assign stat_clr  = rd_stat ? prdata[STAT_W-1:0] : '0;
  assign stat_next = (stat_reg & ~stat_clr) | stat_evt;

  assign rd_mux = sel(req.addr, OFF_MASK)   ? {7'h00, mask_reg}   :
                  sel(req.addr, OFF_EVMASK) ? {7'h00, evmask_reg} :
                  sel(req.addr, OFF_RISE)   ? {7'h00, rise_reg}   :
                  sel(req.addr, OFF_FALL)   ? {7'h00, fall_reg}   :
                  sel(req.addr, OFF_PEND)   ? {7'h00, pend_reg}   :
                  sel(req.addr, OFF_LEVEL)  ? {7'h00, sync2_reg}  :
                  sel(req.addr, OFF_WAKEEN) ? {16'h0000, wakeen_reg} :
                  sel(req.addr, OFF_STAT)   ? {30'h0000_0000, stat_reg}   :
                  sel(req.addr, OFF_STMASK) ? {30'h0000_0000, stmask_reg} :
                  32'h0000_0000;

  // two-flop synchroniser; only the second stage feeds logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= line_in;
      sync2_reg <= sync1_reg;
    end
  end

  // previous level for edge detection; resets low like the synchroniser, so a
  // line idling high shows one rise after reset while the selects are still off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_reg <= '0;
    end
    else
    begin
      prev_reg <= sync2_reg;
    end
  end

  // configuration words load only on a write access to their own offset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_reg <= RST_MASK;
    end
    else if (wr_mask)
    begin
      mask_reg <= req.wdata[NUM_LINES-1:0];
    end
  end

  // event mask gates the one-cycle event pulses, not the pending bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evmask_reg <= RST_MASK;
    end
    else if (wr_evmask)
    begin
      evmask_reg <= req.wdata[NUM_LINES-1:0];
    end
  end

  // rise and fall both set means either edge triggers the line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rise_reg <= RST_EDGE;
    end
    else if (wr_rise)
    begin
      rise_reg <= req.wdata[NUM_LINES-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fall_reg <= RST_EDGE;
    end
    else if (wr_fall)
    begin
      fall_reg <= req.wdata[NUM_LINES-1:0];
    end
  end

  // wake enable exists only for the io lines; upper write bits are ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wakeen_reg <= RST_WAKEEN;
    end
    else if (wr_wakeen)
    begin
      wakeen_reg <= req.wdata[NUM_IO_LINES-1:0];
    end
  end

  // status mask decides which status bits may raise the summary interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stmask_reg <= '0;
    end
    else if (wr_stmask)
    begin
      stmask_reg <= req.wdata[STAT_W-1:0];
    end
  end

  // bus handshake: ready, error and read data stand for the access cycle only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= EIEL_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end
    else
    begin
      phase_reg <= phase_next;
      pready    <= access_next;
      pslverr   <= access_next && !addr_ok;
      prdata    <= (access_next && !req.wr) ? rd_mux : 32'h0000_0000;
    end
  end

  // pending is sticky until cleared by software; status is sticky until read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_reg <= '0;
      stat_reg <= '0;
    end
    else
    begin
      pend_reg <= pend_next;
      stat_reg <= stat_next;
    end
  end

  // requests to the interrupt controller; a mask bit of one lets a line through
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_irq   <= '0;
      line_event <= '0;
      wakeup_req <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      line_irq   <= pend_next & mask_reg;
      line_event <= trig & evmask_reg;
      wakeup_req <= wake_hit;
      irq        <= |(stat_next & stmask_reg);
    end
  end

endmodule

// ---- common/eiel_pkg.sv ----
// package for the edge interrupt/event line controller
// assumes a 32-bit apb slave, one clock, registers on aligned words
package eiel_pkg;

  localparam int          NUM_LINES    = 25;
  localparam int          NUM_IO_LINES = 16;
  localparam int          ADDR_W       = 12;

  // register byte offsets
  localparam logic [11:0] OFF_MASK     = 12'h0_000;
  localparam logic [11:0] OFF_EVMASK   = 12'h0_004;
  localparam logic [11:0] OFF_RISE     = 12'h0_008;
  localparam logic [11:0] OFF_FALL     = 12'h0_00C;
  localparam logic [11:0] OFF_SWTRIG   = 12'h0_010;
  localparam logic [11:0] OFF_PEND     = 12'h0_014;
  localparam logic [11:0] OFF_LEVEL    = 12'h0_018;
  localparam logic [11:0] OFF_WAKEEN   = 12'h0_01C;
  localparam logic [11:0] OFF_STAT     = 12'h0_020;
  localparam logic [11:0] OFF_STMASK   = 12'h0_024;

  // reset values
  localparam logic [24:0] RST_MASK     = 25'h000_0000;
  localparam logic [24:0] RST_EDGE     = 25'h000_0000;
  localparam logic [15:0] RST_WAKEEN   = 16'h0000;

  // controller status bit positions
  localparam int          STAT_ANY_PEND = 0;
  localparam int          STAT_WAKE     = 1;
  localparam int          STAT_W        = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic [31:0]       wdata;
  } eiel_req_t;

  typedef enum logic [1:0] {
    EIEL_IDLE   = 2'b00,
    EIEL_ACCESS = 2'b01
  } eiel_phase_t;

endpackage

// ---- tb/eiel_chk.sv ----
// checker for the line controller bus and pending outputs
// assumes it is bound to eiel_top and sees only its ports
`timescale 1ns/10ps
module eiel_chk
  import eiel_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [ADDR_W-1:0]    paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [NUM_LINES-1:0] line_in,
  input wire logic [NUM_LINES-1:0] line_irq,
  input wire logic [NUM_LINES-1:0] line_event
);
  logic [2:0] quiet_reg;
  logic       pw;
  assign pw = psel && penable && pwrite && paddr == OFF_PEND;
  // a clear only proves itself once no edge is left in the sync pipe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quiet_reg <= 3'h0;
    else if ($changed(line_in))
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7)
      quiet_reg <= quiet_reg + 3'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_once_a: assert property (pready |=> !pready) else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("data idle");
  unmapped_a: assert property (psel && penable && paddr > OFF_STMASK |-> pslverr)
    else $error("unmapped accepted");
  pend_clear_a: assert property (pw && quiet_reg == 3'h7 |-> ##2
    (line_irq & $past(pwdata[24:0], 2)) == 25'h0) else $error("not cleared");
  pend_keep_a: assert property (pw |-> ##2 ((line_irq | $past(pwdata[24:0], 2)) &
    $past(line_irq, 2)) == $past(line_irq, 2)) else $error("lost pending");
  event_pulse_a: assert property (line_event != 25'h0 |=> line_event == 25'h0)
    else $error("event held");
endmodule

// ---- tb/eiel_nested_vector_irq_ctrl_model.sv ----
// interrupt controller stand-in: counts wake and event pulses
// assumes registered pulses on pclk from the controller
`timescale 1ns/10ps
module eiel_irq_ctrl_model
  import eiel_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [NUM_LINES-1:0] line_event,
  input  wire logic                 wakeup_req,
  output logic      [7:0]           wake_cnt,
  output logic      [7:0]           ev_cnt
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {wake_cnt, ev_cnt} <= 16'h0000;
    else
      {wake_cnt, ev_cnt} <= {wake_cnt + {7'h00, wakeup_req}, ev_cnt + {7'h00, |line_event}};
  end
endmodule

// ---- tb/eiel_top_tb.sv ----
// self-checking bench for the line controller
// assumes package, design, checker and model compiled first
`timescale 1ns/10ps
module eiel_top_tb;
  import eiel_pkg::*;
  logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                 pwrite = 1'b0, pready, pslverr, wakeup_req, irq;
  logic [ADDR_W-1:0]    paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0, prdata, rd_val;
  logic [NUM_LINES-1:0] line_in = 25'h0, line_irq, line_event;
  logic [7:0]           wake_cnt, ev_cnt, w0, e0;
  logic                 err_val;
  int                   bad_count = 0, samples_checked = 0;
  eiel_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_in(line_in), .line_irq(line_irq), .line_event(line_event),
    .wakeup_req(wakeup_req), .irq(irq));
  eiel_irq_ctrl_model ctrl_u (.pclk(pclk), .presetn(presetn), .line_event(line_event),
    .wakeup_req(wakeup_req), .wake_cnt(wake_cnt), .ev_cnt(ev_cnt));
  initial
  begin
    forever #50 pclk = ~pclk;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_val = prdata;
    err_val = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic lines(input logic [24:0] v);
    @(posedge pclk);
    line_in <= v;
    repeat (6) @(posedge pclk);
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    bad_count++;
    results;
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, OFF_RISE, 32'h0);
    chk(rd_val, 32'h0);
    chk({31'h0, err_val}, 32'h0);
    xfer(1'b0, 12'h028, 32'h0);
    chk(rd_val, 32'h0);
    chk({31'h0, err_val}, 32'h1);
    xfer(1'b1, OFF_MASK, 32'h01FF_FFFF);
    xfer(1'b1, OFF_EVMASK, 32'h01FF_FFFF);
    xfer(1'b1, OFF_RISE, 32'h0000_0005);
    xfer(1'b1, OFF_FALL, 32'h0000_0006);
    xfer(1'b1, OFF_STMASK, 32'h0000_0001);
    xfer(1'b1, OFF_WAKEEN, 32'h0000_FFFF);
    lines(25'h000_0007);
    chk({7'h00, line_irq}, 32'h0000_0005);
    chk({31'h0, irq}, 32'h1);
    lines(25'h000_0000);
    chk({7'h00, line_irq}, 32'h0000_0007);
    xfer(1'b0, OFF_STAT, 32'h0);
    chk(rd_val, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, OFF_PEND, 32'h0);
    repeat (3) @(posedge pclk);
    chk({7'h00, line_irq}, 32'h0000_0007);
    xfer(1'b1, OFF_PEND, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk({7'h00, line_irq}, 32'h0000_0005);
    xfer(1'b0, OFF_PEND, 32'h0);
    chk(rd_val, 32'h0000_0005);
    xfer(1'b1, OFF_MASK, 32'h0000_0004);
    repeat (3) @(posedge pclk);
    chk({7'h00, line_irq}, 32'h0000_0004);
    xfer(1'b1, OFF_MASK, 32'h01FF_FFFF);
    xfer(1'b1, OFF_STMASK, 32'h0);
    xfer(1'b1, OFF_RISE, 32'h01FF_FFFF);
    xfer(1'b1, OFF_PEND, 32'h01FF_FFFF);
    {w0, e0} = {wake_cnt, ev_cnt};
    lines(25'h1FF_0000);
    chk({7'h00, line_irq}, 32'h01FF_0000);
    chk({24'h0, wake_cnt, ev_cnt}, {24'h0, w0, e0 + 8'h01});
    chk({31'h0, irq}, 32'h0);
    lines(25'h1FF_FFFF);
    chk({7'h00, line_irq}, 32'h01FF_FFFF);
    chk({24'h0, wake_cnt}, {24'h0, w0 + 8'h01});
    xfer(1'b0, OFF_LEVEL, 32'h0);
    chk(rd_val, 32'h01FF_FFFF);
    xfer(1'b1, OFF_PEND, 32'h01FF_FFFF);
    xfer(1'b1, OFF_SWTRIG, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    chk({7'h00, line_irq}, 32'h0000_0008);
    chk({24'h0, wake_cnt}, {24'h0, w0 + 8'h02});
    results;
  end
endmodule
bind eiel_top eiel_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .line_in(line_in), .line_irq(line_irq), .line_event(line_event));
